// >>> rtl/ff_stage_command_forwarding.sv
// Input handling and in-order forwarding for one fixed-function stage
//
// Notes on behaviour
// - State commands captured if addressed, then forwarded.
// - Control operations acted on, then forwarded.
// - Front stage turns draw_cmd into fetch parameters.
// - Fetch executes draws, writes entries, emits vertices.
// - Later stages take topologies as vertex packet sequences.
// - Front sends partition values to manager, forwards indication.
// - Fetch stage ignores partition changes for itself.
// - On partition change, drain current tasks first.
// - Then request new handles, use only those.
// - Handles not in flight released immediately.
// - In-flight handles released after downstream consumes them.
// - Front and fetch only forward state_pointer_cmd.
// - Pointer stages capture own pointer for later work.
// - State pointers stay in order with all traffic.
// - Geometry and trim take enable bit, gate pointer.
`timescale 1ns/10ps
`default_nettype none
module ff_stage_command_forwarding
   import stage_pkg::*;
#(
   parameter stage_kind_type STAGE = SK_SHADER
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // Upstream link (command input for the front stage)
   input  wire logic                 inValid,
   output logic                      inReady,
   input  wire pkt_kind_type         inKind,
   input  wire logic [DATA_W-1:0]    inData,
   // Downstream link
   output logic                      outValid,
   input  wire logic                 outReady,
   output pkt_kind_type              outKind,
   output logic      [DATA_W-1:0]    outData,
   // Own work status
   input  wire logic                 tasksIdle,
   // Handle consumption reported by downstream
   input  wire logic                 consumedValid,
   input  wire logic                 consumedGen,
   // Handle release and allocation towards the buffer manager
   output logic                      relValid,
   output logic      [HANDLE_W-1:0]  relCount,
   output logic                      allocReq,
   input  wire logic                 allocGrant,
   input  wire logic [HANDLE_W-1:0]  allocCount,
   output logic                      handleGen,
   // Partition values to the global buffer manager
   output logic                      mgrValid,
   output logic      [DATA_W-1:0]    mgrData,
   // Entry buffer writes by the fetch stage
   output logic                      entryWrValid,
   output logic      [INDEX_W-1:0]   entryWrIndex,
   // Captured state and control actions
   output logic      [PTR_W-1:0]     statePtr,
   output logic                      stageEnabled,
   output logic      [STATE_W-1:0]   stageState,
   output logic                      ctrlValid,
   output logic      [CODE_W-1:0]    ctrlCode
);

   ////////////////////////////////////////////////////////////////////////
   // Stage capability decoding

   // Stages that own buffer entries and track handles
   function automatic logic ownsEntries(stage_kind_type k);
      return (k != SK_FRONT) && (k != SK_FETCH);
   endfunction : ownsEntries

   // Stages that keep a state-block pointer
   function automatic logic takesPointer(stage_kind_type k);
      return (k != SK_FRONT) && (k != SK_FETCH);
   endfunction : takesPointer

   // Stages whose pointer is gated by an enable bit
   function automatic logic hasEnable(stage_kind_type k);
      return (k == SK_GEOMETRY) || (k == SK_TRIM);
   endfunction : hasEnable

   localparam logic OWNER = ownsEntries(STAGE);
   localparam logic PTRST = takesPointer(STAGE);
   localparam logic GATED = hasEnable(STAGE);
   localparam logic FRONT = (STAGE == SK_FRONT);
   localparam logic FETCH = (STAGE == SK_FETCH);

   typedef struct packed {
      fsm_state_type        st;
      logic [HANDLE_W-1:0]  owned;
      logic [HANDLE_W-1:0]  inFlight;
      logic [HANDLE_W-1:0]  oldInFlight;
      logic                 gen;
      logic                 allocReq;
      logic                 relValid;
      logic [HANDLE_W-1:0]  relCount;
      logic                 mgrValid;
      logic [DATA_W-1:0]    mgrData;
      logic                 wrValid;
      logic [INDEX_W-1:0]   wrIndex;
      logic [COUNT_W-1:0]   emitCnt;
      logic [INDEX_W-1:0]   emitIdx;
      logic [PTR_W-1:0]     ptr;
      logic                 enabled;
      logic [STATE_W-1:0]   state;
      logic                 ctrlValid;
      logic [CODE_W-1:0]    ctrlCode;
   } stage_state_type;

   stage_state_type r;
   stage_state_type nxt;
   logic            accept;
   logic            pushValid;
   logic            pushReady;
   logic [WORD_W-1:0] pushWord;
   logic [WORD_W-1:0] popWord;
   logic            curHit;
   logic            oldHit;
   logic            noHandle;
   logic [HANDLE_W-1:0] drainFree;

   ////////////////////////////////////////////////////////////////////////
   // Consumption reports, split by handle generation
   assign curHit = consumedValid && (consumedGen == r.gen) &&
                   (r.inFlight != '0);
   assign oldHit = consumedValid && (consumedGen != r.gen) &&
                   (r.oldInFlight != '0);
   // Handles free at the moment of draining
   assign drainFree = HANDLE_W'(r.owned - r.inFlight + {5'h00, curHit});
   // A vertex packet at an owning stage needs a spare handle
   assign noHandle = OWNER && (inKind == PK_VERTEX) &&
                     (r.owned <= r.inFlight);

   // Input handshake only in the idle state with room downstream
   assign inReady = (r.st == ST_IDLE) && pushReady && !noHandle;
   assign accept  = inValid && inReady;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic of the stage controller
   always_comb begin
      nxt           = r;
      nxt.relValid  = 1'b0;
      nxt.mgrValid  = 1'b0;
      nxt.wrValid   = 1'b0;
      nxt.ctrlValid = 1'b0;
      pushValid     = 1'b0;
      pushWord      = {inKind, inData};
      // Downstream consumption frees current or old handles
      if (curHit) begin
         nxt.inFlight = HANDLE_W'(r.inFlight - ONE_HANDLE);
      end
      if (oldHit) begin
         nxt.oldInFlight = HANDLE_W'(r.oldInFlight - ONE_HANDLE);
         nxt.relValid    = 1'b1;
         nxt.relCount    = ONE_HANDLE;
      end
      case (r.st)
         ST_ALLOC: begin
            // Wait for the newly allocated handles
            if (allocGrant) begin
               nxt.owned    = allocCount;
               nxt.allocReq = 1'b0;
               nxt.st       = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (accept) begin
               pushValid = 1'b1;
               case (inKind)
                  PK_STATE: begin
                     if (inData[SEL_MSB:SEL_LSB] == STAGE) begin
                        nxt.state = inData[STATE_MSB:0];
                     end
                  end
                  PK_CONTROL: begin
                     nxt.ctrlValid = 1'b1;
                     nxt.ctrlCode  = inData[CODE_MSB:0];
                  end
                  PK_VERTEX: begin
                     if (OWNER) begin
                        nxt.inFlight = HANDLE_W'(nxt.inFlight + ONE_HANDLE);
                     end
                  end
                  PK_DRAW: begin
                     if (FRONT) begin
                        pushWord = {PK_DRAW_PARAMS, inData};
                     end
                  end
                  PK_DRAW_PARAMS: begin
                     if (FETCH) begin
                        pushValid = 1'b0;
                        if (inData[COUNT_MSB:0] != '0) begin
                           nxt.st      = ST_EMIT;
                           nxt.emitCnt = inData[COUNT_MSB:0];
                           nxt.emitIdx = inData[START_MSB:START_LSB];
                        end
                     end
                  end
                  PK_PARTITION: begin
                     if (FRONT) begin
                        nxt.mgrValid = 1'b1;
                        nxt.mgrData  = inData;
                        pushWord     = {PK_PART_CHANGED, ZERO_DATA};
                     end
                  end
                  PK_PART_CHANGED: begin
                     if (!FETCH) begin
                        nxt.st = ST_DRAIN;
                     end
                  end
                  PK_STATE_PTR: begin
                     if (PTRSTAGE_OK()) begin
                        nxt.ptr = inData[PTR_MSB:PTR_LSB];
                     end
                     if (GATED) begin
                        nxt.enabled = inData[ENABLE_BIT];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_DRAIN: begin
            // Release idle handles once own work and old handles are done
            if (tasksIdle && (r.oldInFlight == '0)) begin
               nxt.relValid    = 1'b1;
               nxt.relCount    = drainFree;
               nxt.oldInFlight = nxt.inFlight;
               nxt.inFlight    = '0;
               nxt.owned       = '0;
               nxt.gen         = !r.gen;
               nxt.allocReq    = 1'b1;
               nxt.st          = ST_ALLOC;
            end
         end
         ST_EMIT: begin
            // One vertex packet per entry written
            pushValid = 1'b1;
            pushWord  = {PK_VERTEX, r.emitIdx, VTX_LOW};
            if (pushReady) begin
               nxt.wrValid = 1'b1;
               nxt.wrIndex = r.emitIdx;
               nxt.emitIdx = INDEX_W'(r.emitIdx + 1'b1);
               nxt.emitCnt = COUNT_W'(r.emitCnt - ONE_COUNT);
               if (r.emitCnt == ONE_COUNT) begin
                  nxt.st = ST_IDLE;
               end
            end
         end
         default: begin
            nxt.st = ST_IDLE;
         end
      endcase
   end

   // Pointer stages take the pointer unless a gated stage is being disabled
   function automatic logic PTRSTAGE_OK();
      return PTRST && (!GATED || inData[ENABLE_BIT]);
   endfunction : PTRSTAGE_OK

   // State register; owning stages start by requesting handles
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r          <= '0;
         r.st       <= OWNER ? ST_ALLOC : ST_IDLE;
         r.allocReq <= OWNER;
         r.ptr      <= RST_PTR;
         r.enabled  <= GATED ? RST_ENABLE : 1'b1;
         r.state    <= RST_STATE;
      end else begin
         r <= nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ordered output queue towards the downstream stage
   fifo_buffer #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) outQueue (
      .clk      (clk),
      .reset_n  (reset_n),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inWord   (pushWord),
      .outValid (outValid),
      .outReady (outReady),
      .outWord  (popWord)
   );

   // Output drive
   assign outKind      = pkt_kind_type'(popWord[WORD_W-1:DATA_W]);
   assign outData      = popWord[DATA_W-1:0];
   assign relValid     = r.relValid;
   assign relCount     = r.relCount;
   assign allocReq     = r.allocReq;
   assign handleGen    = r.gen;
   assign mgrValid     = r.mgrValid;
   assign mgrData      = r.mgrData;
   assign entryWrValid = r.wrValid;
   assign entryWrIndex = r.wrIndex;
   assign statePtr     = r.ptr;
   assign stageEnabled = r.enabled;
   assign stageState   = r.state;
   assign ctrlValid    = r.ctrlValid;
   assign ctrlCode     = r.ctrlCode;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_OUT_HOLD: assert property (
      outValid && !outReady |=> outValid && $stable(outKind) &&
                                $stable(outData))
      else $error("Downstream word changed before it was taken");
   AST_STATE_FWD: assert property (
      accept && inKind == PK_STATE |-> pushValid &&
                                       pushWord == {inKind, inData})
      else $error("State command not forwarded unchanged");
   AST_CTRL_ACT: assert property (
      accept && inKind == PK_CONTROL |=> ctrlValid &&
                                   ctrlCode == $past(inData[CODE_MSB:0]))
      else $error("Control operation action missing");
   AST_MGR_SEND: assert property (
      FRONT && accept && inKind == PK_PARTITION |=> mgrValid &&
                                   mgrData == $past(inData))
      else $error("Partition values not sent to manager");
   AST_FETCH_NO_DRAIN: assert property (
      FETCH |-> r.st != ST_DRAIN && !allocReq)
      else $error("Fetch stage reacted to a partition change");
   AST_DRAIN_WAIT: assert property (
      r.st == ST_DRAIN && !tasksIdle && !oldHit |=>
         r.st == ST_DRAIN && !relValid)
      else $error("Release began before tasks completed");
   AST_FREE_RELEASE: assert property (
      r.st == ST_DRAIN && tasksIdle && r.oldInFlight == '0 |=>
         relValid && relCount == $past(drainFree) && allocReq)
      else $error("Free handles not released at once");
   AST_LATE_RELEASE: assert property (
      oldHit |=> relValid && relCount == ONE_HANDLE)
      else $error("Consumed old handle not released");
   AST_NEW_HANDLES: assert property (
      r.st == ST_ALLOC && allocGrant |=> r.st == ST_IDLE &&
                                   r.owned == $past(allocCount))
      else $error("New handles not taken up");
   AST_PTR_TAKE: assert property (
      accept && inKind == PK_STATE_PTR && PTRST &&
      (!GATED || inData[ENABLE_BIT]) |=>
         statePtr == $past(inData[PTR_MSB:PTR_LSB]))
      else $error("State pointer not captured");
   AST_PTR_GATED: assert property (
      accept && inKind == PK_STATE_PTR && GATED && !inData[ENABLE_BIT]
         |=> $stable(statePtr) && !stageEnabled)
      else $error("Disabled stage took its pointer");
   AST_EMIT_START: assert property (
      FETCH && accept && inKind == PK_DRAW_PARAMS &&
      inData[COUNT_MSB:0] != '0 |=> r.st == ST_EMIT && pushValid)
      else $error("Draw not executed by fetch");

   COV_PARTITION: cover property (r.st == ST_DRAIN ##[1:20] r.st == ST_ALLOC);
   COV_LATE:      cover property (oldHit);
   COV_PTR:       cover property (accept && inKind == PK_STATE_PTR);
   COV_FULL:      cover property (pushValid && !pushReady);

endmodule : ff_stage_command_forwarding
`default_nettype wire

// >>> rtl/stage_pkg.sv
// Shared types and constants for the pipeline stage input handler
package stage_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths and FIFO depth
   localparam int DATA_W   = 32;
   localparam int KIND_W   = 3;
   localparam int WORD_W   = KIND_W + DATA_W;
   localparam int HANDLE_W = 6;
   localparam int PTR_W    = 27;
   localparam int STATE_W  = 28;
   localparam int CODE_W   = 4;
   localparam int INDEX_W  = 24;
   localparam int COUNT_W  = 8;
   localparam int FIFO_DEPTH = 16;

   ////////////////////////////////////////////////////////////////////////
   // Field positions inside a packet's data word
   localparam int PTR_LSB    = 5;
   localparam int PTR_MSB    = 31;
   localparam int ENABLE_BIT = 0;
   localparam int SEL_LSB    = 28;
   localparam int SEL_MSB    = 31;
   localparam int STATE_MSB  = 27;
   localparam int CODE_MSB   = 3;
   localparam int COUNT_MSB  = 7;
   localparam int START_LSB  = 8;
   localparam int START_MSB  = 31;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and fixed constants
   localparam logic [PTR_W-1:0]    RST_PTR     = 27'h0000000;
   localparam logic [STATE_W-1:0]  RST_STATE   = 28'h0000000;
   localparam logic                RST_ENABLE  = 1'h0;
   localparam logic [HANDLE_W-1:0] ONE_HANDLE  = 6'h01;
   localparam logic [COUNT_W-1:0]  ONE_COUNT   = 8'h01;
   localparam logic [7:0]          VTX_LOW     = 8'h00;
   localparam logic [DATA_W-1:0]   ZERO_DATA   = 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // Packet kinds travelling between stages
   typedef enum logic [KIND_W-1:0] {
      PK_STATE        = 3'b000,  // Pipelined state command
      PK_CONTROL      = 3'b001,  // Control operation
      PK_VERTEX       = 3'b010,  // Vertex information packet
      PK_DRAW         = 3'b011,  // draw_cmd at the command input
      PK_DRAW_PARAMS  = 3'b100,  // Draw parameters, front to fetch
      PK_PARTITION    = 3'b101,  // buffer_partition_cmd with values
      PK_PART_CHANGED = 3'b110,  // Partition-changed indication only
      PK_STATE_PTR    = 3'b111   // state_pointer_cmd
   } pkt_kind_type;

   // Which stage an instance implements
   typedef enum logic [3:0] {
      SK_FRONT    = 4'b0000,
      SK_FETCH    = 4'b0001,
      SK_SHADER   = 4'b0010,
      SK_GEOMETRY = 4'b0011,
      SK_TRIM     = 4'b0100,
      SK_SETUP    = 4'b0101,
      SK_PIXEL    = 4'b0110
   } stage_kind_type;

   // Stage controller states
   typedef enum logic [1:0] {
      ST_ALLOC = 2'b00,
      ST_IDLE  = 2'b01,
      ST_DRAIN = 2'b10,
      ST_EMIT  = 2'b11
   } fsm_state_type;

endpackage : stage_pkg

// >>> rtl/fifo_buffer.sv
// Synchronous valid/ready FIFO between a stage and its downstream link
`timescale 1ns/10ps
`default_nettype none
module fifo_buffer #(
   parameter int WIDTH = 35,
   parameter int DEPTH = 16   // Power of two
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inWord,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outWord
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } fifo_state_type;

   fifo_state_type r;
   fifo_state_type nxt;
   logic           full;
   logic           empty;

   ////////////////////////////////////////////////////////////////////////
   // Status from the pointers, extra bit tells full from empty
   assign empty    = (r.wp == r.rp);
   assign full     = (r.wp[AW] != r.rp[AW]) &&
                     (r.wp[AW-1:0] == r.rp[AW-1:0]);
   assign inReady  = !full;
   assign outValid = !empty;
   assign outWord  = r.mem[r.rp[AW-1:0]];

   // Next state of storage and pointers
   always_comb begin
      nxt = r;
      if (inValid && !full) begin
         nxt.mem[r.wp[AW-1:0]] = inWord;
         nxt.wp = (AW+1)'(r.wp + 1'b1);
      end
      if (outReady && !empty) begin
         nxt.rp = (AW+1)'(r.rp + 1'b1);
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

endmodule : fifo_buffer
`default_nettype wire

// >>> test/down_stage_model.sv
// Downstream stage model: random stalls and handle use reports
`timescale 1ns/10ps
`default_nettype none
module down_stage_model
   import stage_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Link from the stage under test
   input  wire logic              outValid,
   output logic                   outReady,
   input  wire pkt_kind_type      outKind,
   input  wire logic [DATA_W-1:0] outData,
   // Stall request
   input  wire logic              stall,
   // Handle consumption reports
   output logic                   consumedValid,
   output logic                   consumedGen,
   // Accepted word for the bench
   output logic                   takeValid,
   output pkt_kind_type           takeKind,
   output logic      [DATA_W-1:0] takeData
);
   logic partGen;

   // Take on valid and ready; ready moves just after each edge
   always @(posedge clk) begin
      takeValid     <= reset_n && outValid && outReady;
      takeKind      <= outKind;
      takeData      <= outData;
      consumedValid <= reset_n && outValid && outReady && outKind == PK_VERTEX;
      consumedGen   <= partGen;
      outReady      <= #1 !stall && ($urandom % 4 != 0);
      // Handles behind a partition indication belong to the next generation
      if (!reset_n) begin
         partGen <= 1'b0;
      end else if (outValid && outReady && outKind == PK_PART_CHANGED) begin
         partGen <= !partGen;
      end
   end
endmodule : down_stage_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the stage input handler, geometry role
`timescale 1ns/10ps
`default_nettype none
module tb
   import stage_pkg::*;
;
   logic clk = 1'b0, reset_n, inValid, inReady, outValid, outReady, tasksIdle;
   logic consumedValid, consumedGen, relValid, allocReq, allocGrant;
   logic handleGen, mgrValid, entryWrValid, stageEnabled, ctrlValid;
   logic stall, takeValid;
   pkt_kind_type inKind, outKind, takeKind;
   logic [DATA_W-1:0] inData, outData, mgrData, takeData;
   logic [HANDLE_W-1:0] relCount, allocCount;
   logic [INDEX_W-1:0] entryWrIndex;
   logic [PTR_W-1:0] statePtr, ptrM;
   logic [STATE_W-1:0] stageState, stM;
   logic [CODE_W-1:0] ctrlCode;
   logic [WORD_W-1:0] expQ[$];
   pkt_kind_type kinds[4] = '{PK_STATE, PK_CONTROL, PK_VERTEX, PK_STATE_PTR};
   int errorCnt = 0, checks = 0;

   ff_stage_command_forwarding #(.STAGE(SK_GEOMETRY)) dut (.clk(clk),
      .reset_n(reset_n), .inValid(inValid), .inReady(inReady),
      .inKind(inKind), .inData(inData), .outValid(outValid),
      .outReady(outReady), .outKind(outKind), .outData(outData),
      .tasksIdle(tasksIdle), .consumedValid(consumedValid),
      .consumedGen(consumedGen), .relValid(relValid), .relCount(relCount),
      .allocReq(allocReq), .allocGrant(allocGrant),
      .allocCount(allocCount), .handleGen(handleGen), .mgrValid(mgrValid),
      .mgrData(mgrData), .entryWrValid(entryWrValid),
      .entryWrIndex(entryWrIndex), .statePtr(statePtr),
      .stageEnabled(stageEnabled), .stageState(stageState),
      .ctrlValid(ctrlValid), .ctrlCode(ctrlCode));

   down_stage_model far (.clk(clk), .reset_n(reset_n), .outValid(outValid),
      .outReady(outReady), .outKind(outKind), .outData(outData),
      .stall(stall), .consumedValid(consumedValid),
      .consumedGen(consumedGen), .takeValid(takeValid),
      .takeKind(takeKind), .takeData(takeData));

   ////////////////////////////////////////////////////////////////////////
   // Clock
   always #5 clk = ~clk;

   // Compare one value
   task automatic chk(input string what, input logic [WORD_W-1:0] exp,
                      input logic [WORD_W-1:0] got);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Offer one word until taken, then check captured fields
   task automatic send(input pkt_kind_type k, input logic [DATA_W-1:0] d);
      logic ok;
      inValid = 1'b1;
      inKind = k;
      inData = d;
      ok = 1'b0;
      while (!ok) begin
         #3;
         ok = inReady;
         @(posedge clk);
      end
      expQ.push_back({k, d});
      #1;
      if (k == PK_CONTROL) begin
         chk("ctrlValid", 1, ctrlValid);
         chk("ctrlCode", d[CODE_MSB:0], ctrlCode);
      end
      if (k == PK_STATE && d[SEL_MSB:SEL_LSB] == SK_GEOMETRY) stM = d[27:0];
      if (k == PK_STATE) chk("stageState", stM, stageState);
      if (k == PK_STATE_PTR) begin
         if (d[ENABLE_BIT]) ptrM = d[PTR_MSB:PTR_LSB];
         chk("stageEnabled", d[ENABLE_BIT], stageEnabled);
         chk("statePtr", ptrM, statePtr);
      end
   endtask : send

   // Wait until the queue and the far side are quiet
   task automatic drain();
      inValid = 1'b0;
      while (expQ.size() != 0) @(posedge clk);
      repeat (3) @(posedge clk);
      #1;
   endtask : drain

   // Grant a handle count for one cycle
   task automatic grant(input logic [HANDLE_W-1:0] c);
      allocGrant = 1'b1;
      allocCount = c;
      @(posedge clk);
      #1;
      allocGrant = 1'b0;
   endtask : grant

   // Wait for a release pulse; a missing one counts as a mismatch
   task automatic waitRel();
      int w;
      w = 0;
      while (relValid !== 1'b1 && w < 20) begin
         @(posedge clk);
         #1;
         w++;
      end
      chk("relTimeout", 0, w == 20);
   endtask : waitRel

   // Random state, control, vertex and state pointer words
   task automatic traffic(input int cnt);
      for (int i = 0; i < cnt; i++) send(kinds[$urandom % 4], $urandom);
   endtask : traffic

   // Verdict
   task automatic endSim();
      $display("checks %0d errors %0d", checks, errorCnt);
      if (errorCnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : endSim

   // Forwarded words in order
   always @(posedge clk) begin
      if (takeValid === 1'b1) begin
         chk("outWord", expQ.size() ? expQ.pop_front() : 'x,
             {takeKind, takeData});
      end
   end

   // Watchdog
   initial begin
      #500000;
      errorCnt++;
      endSim();
   end

   // Main sequence
   initial begin
      void'($urandom(32'h7436));
      {reset_n, inValid, allocGrant, stall, inData, stM, ptrM} = '0;
      inKind = PK_STATE;
      {allocCount, tasksIdle} = '0;
      repeat (4) @(posedge clk);
      #1;
      reset_n = 1'b1;
      chk("allocReq", 1, allocReq);
      chk("stageEnabled", 0, stageEnabled);
      grant(6'h04);
      tasksIdle = 1'b1;
      traffic(60);
      drain();
      tasksIdle = 1'b0;
      send(PK_PART_CHANGED, 32'h00000000);
      inValid = 1'b0;
      repeat (6) begin
         chk("relValid", 0, relValid);
         @(posedge clk);
         #1;
      end
      tasksIdle = 1'b1;
      waitRel();
      chk("relCount", 6'h04, relCount);
      chk("handleGen", 1, handleGen);
      chk("allocReq", 1, allocReq);
      grant(6'h02);
      traffic(30);
      drain();
      stall = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      repeat (FIFO_DEPTH) send(PK_STATE, 32'h00000000);
      #3;
      chk("inReady", 0, inReady);
      @(posedge clk);
      #1;
      stall = 1'b0;
      send(PK_CONTROL, $urandom);
      drain();
      // Partition while a vertex handle is still queued downstream
      stall = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      send(PK_VERTEX, $urandom);
      send(PK_PART_CHANGED, 32'h00000000);
      inValid = 1'b0;
      waitRel();
      chk("relCount", 6'h01, relCount);
      grant(6'h02);
      stall = 1'b0;
      waitRel();
      chk("relCount", 6'h01, relCount);
      drain();
      endSim();
   end
endmodule : tb
`default_nettype wire
